// ---- wdog_pkg.sv ----
// constants for the watchdog and reset output block
package wdog_pkg;
	localparam int unsigned CLK_HZ                  = 50_000_000;
	localparam int unsigned CLK_PERIOD_NS           = 20;
	// timing figures in their own units
	localparam int unsigned RESET_DELAY_US          = 8500;
	localparam int unsigned TRIGGER_WINDOW_MS       = 48;
	localparam int unsigned RESET_REACTION_MAX_US   = 33;
	localparam int unsigned TIMEOUT_LOW_US          = 1000;
	localparam int unsigned IGNORE_WINDOW_US        = 100000;
	localparam int unsigned DISABLE_FILTER_US       = 1000;
	// time base tick of the internal oscillator, microseconds
	localparam int unsigned TICK_US                 = 1;
	localparam int unsigned TICK_CYCLES             = TICK_US * 1000 / CLK_PERIOD_NS;
	// counts in ticks; least times round up, longest rounds down
	localparam int unsigned RESET_DELAY_TICKS       = (RESET_DELAY_US + TICK_US - 1) / TICK_US;
	localparam int unsigned TRIGGER_WINDOW_TICKS    = TRIGGER_WINDOW_MS * 1000 / TICK_US;
	localparam int unsigned TIMEOUT_LOW_TICKS       = (TIMEOUT_LOW_US + TICK_US - 1) / TICK_US;
	localparam int unsigned IGNORE_WINDOW_TICKS     = (IGNORE_WINDOW_US + TICK_US - 1) / TICK_US;
	localparam int unsigned DISABLE_FILTER_TICKS    = (DISABLE_FILTER_US + TICK_US - 1) / TICK_US;
	// supply-loss reaction: cycles, rounded down, at least one
	localparam int unsigned REACTION_CYCLES_RAW     = RESET_REACTION_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned REACTION_CYCLES         = (REACTION_CYCLES_RAW < 1) ? 1 : REACTION_CYCLES_RAW;
	localparam int unsigned TICK_W                  = 24;
endpackage : wdog_pkg

// ---- tick_if.sv ----
// time base tick carrier between the oscillator divider and the watchdog
`timescale 1ns/1ns
interface tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface : tick_if

// ---- wdog_timebase.sv ----
// internal oscillator time base: one-cycle tick every TICK_CYCLES clocks
`timescale 1ns/1ns
module wdog_timebase #(
	parameter int unsigned DIV = wdog_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// tick out
	tick_if.src       tb
);
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

	initial begin
		if (DIV < 1) $error("timebase divider must be at least one");
	end

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         tick_q;
	logic         tick_d;

	// free-running divider, independent of any processor clock
	always_comb begin
		if (cnt_q == W'(DIV - 1)) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end else begin
			cnt_d  = cnt_q + W'(1);
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tb.tick = tick_q;
endmodule : wdog_timebase

// ---- window_watchdog_reset_out.sv ----
// watchdog with combined active-low reset and watchdog output
`timescale 1ns/1ns
module window_watchdog_reset_out #(
	parameter int unsigned RESET_DELAY_TICKS    = wdog_pkg::RESET_DELAY_TICKS,
	parameter int unsigned TRIGGER_WINDOW_TICKS = wdog_pkg::TRIGGER_WINDOW_TICKS,
	parameter int unsigned TIMEOUT_LOW_TICKS    = wdog_pkg::TIMEOUT_LOW_TICKS,
	parameter int unsigned IGNORE_WINDOW_TICKS  = wdog_pkg::IGNORE_WINDOW_TICKS,
	parameter int unsigned DISABLE_FILTER_TICKS = wdog_pkg::DISABLE_FILTER_TICKS,
	parameter int unsigned TICK_CYCLES          = wdog_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// supply supervisor and analog detector levels
	input  wire logic supply_ok,
	input  wire logic disable_level,
	input  wire logic low_current_load,
	// trigger from the processor
	input  wire logic wdog_trigger_in,
	// combined open-drain output, enable low while pulling low
	output logic      reset_wdog_out_n,
	output logic      reset_wdog_oe_n,
	// status
	output logic      wdog_disabled
);
	// one counter width serves every window and the filter
	localparam int unsigned W = wdog_pkg::TICK_W;

	// elaboration checks: every time is at least one tick and fits the counter
	initial begin
		if (TICK_CYCLES < 1)
			$error("time base divider must be at least one clock");
		if (RESET_DELAY_TICKS < 1)
			$error("reset delay must be at least one tick");
		if (TRIGGER_WINDOW_TICKS < 1)
			$error("trigger window must be at least one tick");
		if (TIMEOUT_LOW_TICKS < 1)
			$error("timeout low time must be at least one tick");
		if (IGNORE_WINDOW_TICKS < 1)
			$error("ignore window must be at least one tick");
		if (DISABLE_FILTER_TICKS < 1)
			$error("disable filter time must be at least one tick");
		if (RESET_DELAY_TICKS >= (1 << W))
			$error("reset delay exceeds counter width");
		if (TRIGGER_WINDOW_TICKS >= (1 << W))
			$error("trigger window exceeds counter width");
		if (TIMEOUT_LOW_TICKS >= (1 << W))
			$error("timeout low time exceeds counter width");
		if (IGNORE_WINDOW_TICKS >= (1 << W))
			$error("ignore window exceeds counter width");
		if (DISABLE_FILTER_TICKS >= (1 << W))
			$error("disable filter time exceeds counter width");
	end

	// states of the main sequence:
	// por      - output low while the supply is bad or the reset delay runs
	// ignore   - output high, triggers not required
	// trigger  - output high, a falling edge must arrive before the window ends
	// low      - timeout pulse on the output
	// dis_low  - disabled while the timeout pulse is still being served
	// disabled - output high, no trigger required
	typedef enum logic [2:0] {
		ST_POR,
		ST_IGNORE,
		ST_TRIGGER,
		ST_TIMEOUT_LOW,
		ST_DIS_LOW,
		ST_DISABLED
	} wd_state_e;

	// carrier for the time base pulse
	tick_if tb_if ();

	// internal oscillator time base
	wdog_timebase #(
		.DIV   (TICK_CYCLES)
	) u_timebase (
		.clock (clock),
		.rst   (rst),
		.tb    (tb_if.src)
	);

	// one-cycle time base pulse; windows count it, never a processor clock
	wire logic tick = tb_if.tick;

	// input registers; inputs are synchronous so one stage suffices
	logic trig_q;
	logic trig_d;
	logic trig_prev_q;
	logic trig_prev_d;
	logic dis_q;
	logic dis_d;
	logic lcl_q;
	logic lcl_d;
	logic sup_q;
	logic sup_d;

	// next values of the input stage
	always_comb begin
		trig_d      = wdog_trigger_in;
		trig_prev_d = trig_q;
		dis_d       = disable_level;
		lcl_d       = low_current_load;
		sup_d       = supply_ok;
	end

	// trigger history resets high, the pin's idle level, so no false edge follows
	always_ff @(posedge clock) begin
		if (rst) begin
			trig_q      <= 1'b1;
			trig_prev_q <= 1'b1;
			dis_q       <= 1'b0;
			lcl_q       <= 1'b0;
			sup_q       <= 1'b0;
		end else begin
			trig_q      <= trig_d;
			trig_prev_q <= trig_prev_d;
			dis_q       <= dis_d;
			lcl_q       <= lcl_d;
			sup_q       <= sup_d;
		end
	end

	// only a high-to-low step is a trigger; a held level is not
	// the edge is seen one clock after the pin falls
	wire logic fall = trig_prev_q & ~trig_q;

	// disable filter: level must stay high through DISABLE_FILTER_TICKS time base ticks
	logic [W-1:0] filt_q;
	logic [W-1:0] filt_d;
	logic         dis_ok_q;
	logic         dis_ok_d;

	always_comb begin
		filt_d   = filt_q;
		dis_ok_d = dis_ok_q;
		// any drop of the level restarts the dead time
		if (!dis_q) begin
			filt_d   = '0;
			dis_ok_d = 1'b0;
		// counts time base ticks, so the dead time can fall up to one tick short
		end else if (!dis_ok_q && tick) begin
			if (filt_q == W'(DISABLE_FILTER_TICKS - 1)) begin
				dis_ok_d = 1'b1;
			end else begin
				filt_d = filt_q + W'(1);
			end
		end
	end

	// filter registers
	always_ff @(posedge clock) begin
		if (rst) begin
			filt_q   <= '0;
			dis_ok_q <= 1'b0;
		end else begin
			filt_q   <= filt_d;
			dis_ok_q <= dis_ok_d;
		end
	end

	// main sequence; the shared counter restarts on every state change except low to dis_low
	wd_state_e    st_q;
	wd_state_e    st_d;
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         out_q;
	logic         out_d;
	// the two low requests that share the output pin
	logic         por_req;
	logic         wd_req;

	// end-of-time decodes on the shared counter, true on the last tick only
	logic         por_end;
	logic         ign_end;
	logic         win_end;
	logic         low_end;

	always_comb begin
		por_end = tick && (cnt_q == W'(RESET_DELAY_TICKS - 1));
		ign_end = tick && (cnt_q == W'(IGNORE_WINDOW_TICKS - 1));
		win_end = tick && (cnt_q == W'(TRIGGER_WINDOW_TICKS - 1));
		low_end = tick && (cnt_q == W'(TIMEOUT_LOW_TICKS - 1));
	end

	// next state, counter and output
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		// time advances on the time base pulse only
		if (tick) cnt_d = cnt_q + W'(1);
		case (st_q)
			ST_POR: begin
				// the delay counts only while the supply is good
				if (!sup_q) begin
					cnt_d = '0;
				end else if (por_end) begin
					st_d  = ST_IGNORE;
					cnt_d = '0;
				end
			end
			ST_IGNORE: begin
				// triggers are not required here, so edges are not looked at
				if (dis_ok_q) begin
					st_d  = ST_DISABLED;
					cnt_d = '0;
				end else if (ign_end) begin
					st_d  = ST_TRIGGER;
					cnt_d = '0;
				end
			end
			ST_TRIGGER: begin
				// disable wins over a trigger in the same cycle
				if (dis_ok_q) begin
					st_d  = ST_DISABLED;
					cnt_d = '0;
				end else if (fall) begin
					cnt_d = '0;
				end else if (win_end) begin
					st_d  = ST_TIMEOUT_LOW;
					cnt_d = '0;
				end
			end
			ST_TIMEOUT_LOW: begin
				// the counter keeps running if disable arrives mid-pulse
				if (dis_ok_q) begin
					st_d = ST_DIS_LOW;
				end else if (low_end) begin
					st_d  = ST_IGNORE;
					cnt_d = '0;
				end
			end
			ST_DIS_LOW: begin
				// low time ends early if the load condition ends first
				if (!lcl_q || low_end) begin
					st_d  = ST_DISABLED;
					cnt_d = '0;
				end
			end
			ST_DISABLED: begin
				// counter held clear so leaving starts a fresh ignore window
				cnt_d = '0;
				if (!dis_ok_q) begin
					st_d = ST_IGNORE;
				end
			end
			default: begin
				// unused codes fall back to the reset delay
				st_d  = ST_POR;
				cnt_d = '0;
			end
		endcase
		// supply loss overrides everything and restarts the reset delay
		if (!sup_q) begin
			st_d  = ST_POR;
			cnt_d = '0;
		end
		// combined output: low while the reset logic or the watchdog asks for it
		por_req = (st_d == ST_POR);
		wd_req  = (st_d == ST_TIMEOUT_LOW) || (st_d == ST_DIS_LOW);
		out_d   = !(por_req || wd_req);
	end

	// state, counter and output registers
	always_ff @(posedge clock) begin
		if (rst) begin
			st_q  <= ST_POR;
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	// open drain: enable low while pulling the pin low; the pull-up makes
	// the high level, so level and enable come from the same register
	assign reset_wdog_out_n = out_q;
	assign reset_wdog_oe_n  = out_q;
	assign wdog_disabled    = (st_q == ST_DISABLED) || (st_q == ST_DIS_LOW);
endmodule : window_watchdog_reset_out

// ---- wdog_properties.sv ----
// concurrent checks on the watchdog output block
`timescale 1ns/1ns
module wdog_properties #(
	parameter int unsigned TRIGGER_WINDOW_TICKS = 1,
	parameter int unsigned IGNORE_WINDOW_TICKS  = 1,
	parameter int unsigned DISABLE_FILTER_TICKS = 1,
	parameter int unsigned TICK_CYCLES          = 1
) (
	// clock, reset and levels
	input wire logic clock,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic disable_level,
	input wire logic wdog_trigger_in,
	// outputs
	input wire logic reset_wdog_out_n,
	input wire logic reset_wdog_oe_n,
	input wire logic wdog_disabled
);
	int   idle_q;
	int   dl_q;
	logic trig_q;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// idle counts watched cycles since the last falling edge; ignored edges only shorten it
	always_ff @(posedge clock) begin
		trig_q <= wdog_trigger_in;
		idle_q <= (rst || !reset_wdog_out_n || wdog_disabled || (trig_q && !wdog_trigger_in))
			? 0 : idle_q + 1;
		dl_q   <= (rst || !disable_level) ? 0 : dl_q + 1;
	end
	// output held high after a release step
	sequence s_hold;
		reset_wdog_out_n [*8];
	endsequence
	property p_oe_match; reset_wdog_oe_n == reset_wdog_out_n; endproperty
	a_oe_match: assert property (p_oe_match) else $error("enable differs from output");
	property p_supply_loss; !supply_ok |-> ##[1:2] !reset_wdog_out_n; endproperty
	a_supply_loss: assert property (p_supply_loss) else $error("supply loss not seen");
	property p_por_hold; $rose(supply_ok) |=> !reset_wdog_out_n [*8]; endproperty
	a_por_hold: assert property (p_por_hold) else $error("early release");
	property p_retrigger; $fell(wdog_trigger_in) && reset_wdog_out_n && !wdog_disabled
		&& idle_q > (IGNORE_WINDOW_TICKS + 1) * TICK_CYCLES + 4
		&& idle_q < (TRIGGER_WINDOW_TICKS - 2) * TICK_CYCLES |-> ##2 s_hold;
	endproperty
	a_retrigger: assert property (p_retrigger) else $error("trigger did not restart");
	property p_timeout;
		idle_q <= (IGNORE_WINDOW_TICKS + TRIGGER_WINDOW_TICKS + 2) * TICK_CYCLES + 6;
	endproperty
	a_timeout: assert property (p_timeout) else $error("missed timeout");
	property p_filter; $rose(wdog_disabled) |-> dl_q >= (DISABLE_FILTER_TICKS - 1) * TICK_CYCLES;
	endproperty
	a_filter: assert property (p_filter) else $error("disable too early");
	property p_disabled_high;
		wdog_disabled && reset_wdog_out_n && supply_ok && $past(supply_ok) |=> reset_wdog_out_n;
	endproperty
	a_disabled_high: assert property (p_disabled_high) else $error("low while disabled");
	property p_leave; $fell(disable_level) && wdog_disabled && reset_wdog_out_n
		|-> ##[1:3] !wdog_disabled ##0 s_hold;
	endproperty
	a_leave: assert property (p_leave) else $error("bad disable exit");
endmodule : wdog_properties
bind window_watchdog_reset_out wdog_properties #(
	.TRIGGER_WINDOW_TICKS(TRIGGER_WINDOW_TICKS), .IGNORE_WINDOW_TICKS(IGNORE_WINDOW_TICKS),
	.DISABLE_FILTER_TICKS(DISABLE_FILTER_TICKS), .TICK_CYCLES(TICK_CYCLES)
) u_props (.clock, .rst, .supply_ok, .disable_level, .wdog_trigger_in, .reset_wdog_out_n,
	.reset_wdog_oe_n, .wdog_disabled);

// ---- host_model.sv ----
// processor model serving the watchdog trigger
`timescale 1ns/1ns
module host_model (
	// clock and reset pin
	input  wire logic       clock,
	input  wire logic       reset_wdog_out_n,
	// service control
	input  wire logic       serve,
	input  wire logic [7:0] period,
	// trigger pin
	output logic            wdog_trigger_in
);
	int n = 0;
	initial wdog_trigger_in = 1'b1;
	// a processor in reset stops serving; a stopped one leaves the pin static
	always @(posedge clock) begin
		#2;
		if (serve && reset_wdog_out_n) begin
			n = (n >= period) ? 0 : n + 1;
			wdog_trigger_in = (n >= 2);
		end
	end
endmodule : host_model

// ---- tb_window_watchdog_reset_out.sv ----
// self-checking bench for the watchdog output block
`timescale 1ns/1ns
module tb_window_watchdog_reset_out;
	localparam int TC = 2, RD = 20, TW = 40, LO = 8, IG = 10, FT = 4;
	logic        clock = 0, rst = 1, supply_ok = 1, disable_level = 0, low_current_load = 0;
	logic        serve = 0;
	logic [7:0]  period = 8'h10;
	logic [31:0] rng = 32'h6C38212F;
	wire logic   wdog_trigger_in, reset_wdog_out_n, reset_wdog_oe_n, wdog_disabled;
	int          err_count = 0, n_compared = 0, w, l;
	window_watchdog_reset_out #(.RESET_DELAY_TICKS(RD), .TRIGGER_WINDOW_TICKS(TW),
		.TIMEOUT_LOW_TICKS(LO), .IGNORE_WINDOW_TICKS(IG), .DISABLE_FILTER_TICKS(FT),
		.TICK_CYCLES(TC)) dut (.clock, .rst, .supply_ok, .disable_level, .low_current_load,
		.wdog_trigger_in, .reset_wdog_out_n, .reset_wdog_oe_n, .wdog_disabled);
	host_model host (.clock, .reset_wdog_out_n, .serve, .period, .wdog_trigger_in);
	always #10 clock = ~clock;
	// helpers: step past an edge, compare, time the next low pulse
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#2;
	endtask : cyc
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	task automatic watch(output int wt, output int lt);
		wt = 0;
		lt = 0;
		while (reset_wdog_out_n === 1'b1 && wt < 500) begin cyc(1); wt++; end
		while (reset_wdog_out_n === 1'b0 && lt < 500) begin cyc(1); lt++; end
	endtask : watch
	task automatic print_verdict;
		$display("errors %0d, compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// hang guard, well beyond the longest sequence
	initial begin
		#(20 * 8000);
		err_count++;
		print_verdict();
	end
	initial begin
		cyc(5);
		rst = 0;
		cyc(RD * TC - 6);
		check(reset_wdog_out_n, 0);
		cyc(14);
		check(reset_wdog_out_n, 1);
		serve = 1;
		for (int i = 0; i < 6; i++) begin
			rng = rng ^ (rng << 13);
			rng = rng ^ (rng >> 17);
			rng = rng ^ (rng << 5);
			period = 8'(8 + rng % 50);
			cyc(3 * period + 10);
			check(reset_wdog_out_n, 1);
		end
		while (wdog_trigger_in !== 1'b0) cyc(1);
		serve = 0;
		watch(w, l);
		check(w inside {[TW * TC - 2 : TW * TC + 6]}, 1);
		check(l inside {[LO * TC - 2 : LO * TC + 3]}, 1);
		disable_level = 1;
		cyc(40);
		check({reset_wdog_out_n, wdog_disabled}, 2'b11);
		disable_level = 0;
		cyc(4);
		check(wdog_disabled, 0);
		watch(w, l);
		check((w + 4) inside {[(IG + TW) * TC - 2 : (IG + TW) * TC + 8]}, 1);
		serve = 1;
		period = 8'h28;
		cyc(60);
		disable_level = 1;
		cyc(3);
		disable_level = 0;
		cyc(20);
		check(wdog_disabled, 0);
		disable_level = 1;
		serve = 0;
		cyc(200);
		check({reset_wdog_out_n, wdog_disabled}, 2'b11);
		for (int lc = 1; lc >= 0; lc--) begin
			disable_level = 0;
			w = 0;
			while (reset_wdog_out_n !== 1'b0 && w < 500) begin cyc(1); w++; end
			low_current_load = 1'(lc);
			disable_level = 1;
			l = 0;
			while (reset_wdog_out_n !== 1'b1 && l < 500) begin cyc(1); l++; end
			check(wdog_disabled, 1);
			check(l inside {[(lc ? LO : FT) * TC - 3 : (lc ? LO : FT) * TC + 4]}, 1);
			cyc(40);
			check({reset_wdog_out_n, wdog_disabled}, 2'b11);
		end
		supply_ok = 0;
		cyc(2);
		check({reset_wdog_out_n, reset_wdog_oe_n}, 2'b00);
		supply_ok = 1;
		cyc(RD * TC + 8);
		check(reset_wdog_out_n, 1);
		print_verdict();
	end
endmodule : tb_window_watchdog_reset_out
